// ===== rtl/gcs_pkg.sv
// package for the global configuration and status register bank
// assumes a serial front end that decodes frames into register accesses
package gcs_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [6:0] GCS_ADDR_CONF   = 7'h00;
  localparam logic [6:0] GCS_ADDR_STATUS = 7'h01;
  localparam logic [6:0] GCS_ADDR_COUNT  = 7'h02;

  // ****************************************
  // field positions
  // ****************************************
  localparam int GCS_CONF_W        = 18;
  localparam int GCS_BIT_IRQ_PP    = 12;
  localparam int GCS_BIT_CMP_PP    = 13;
  localparam int GCS_BIT_SMALL_HYS = 14;
  localparam int GCS_BIT_STOP_EN   = 15;
  localparam int GCS_BIT_DIRECT    = 16;
  localparam int GCS_BIT_TEST      = 17;
  localparam int GCS_ST_RESET      = 0;
  localparam int GCS_ST_DRV_ERR    = 1;
  localparam int GCS_ST_PUMP_UNDERVOLTAGE_FLAG      = 2;
  localparam int GCS_STATUS_W      = 3;
  localparam int GCS_COUNT_W       = 8;
  localparam int GCS_COIL_A_LSB    = 0;
  localparam int GCS_COIL_B_LSB    = 16;
  localparam int GCS_COIL_W        = 9;
  localparam int GCS_SCALE_W       = 5;

  // ****************************************
  // reset values and shifts
  // ****************************************
  localparam logic [GCS_CONF_W-1:0]   GCS_CONF_RST   = 18'h0_0000;
  localparam logic [GCS_STATUS_W-1:0] GCS_STATUS_RST = 3'h1;
  localparam logic [GCS_COUNT_W-1:0]  GCS_COUNT_RST  = 8'h00;
  localparam logic [2:0]              GCS_HYS_WIDE   = 3'h4;  // band = 1/16
  localparam logic [2:0]              GCS_HYS_NARROW = 3'h5;  // band = 1/32
  localparam int                      GCS_SCALE_SHIFT = 5;    // scale / 32
  localparam int                      GCS_SYNC_STAGES = 3;

endpackage : gcs_pkg

// ===== rtl/gcs_pin_sync.sv
// three-stage synchroniser for a pin input
// assumes the pin is asynchronous to core_clk_i; output changes once stages two and three agree
`timescale 1ns/1ps
module gcs_pin_sync (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      level_o
);
  import gcs_pkg::*;

  logic [GCS_SYNC_STAGES-1:0] stage;

  // shift chain; first stage is read only by the second
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      stage <= 3'h0;
    end else begin
      stage <= {stage[GCS_SYNC_STAGES-2:0], pin_i};
    end
  end

  // accept a new level only when the last two stages agree, filtering a one-cycle glitch
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      level_o <= 1'b0;
    end else if (stage[1] == stage[2]) begin
      level_o <= stage[2];
    end
  end

endmodule : gcs_pin_sync

// ===== rtl/gcs_diag_drive.sv
// drive stage for one diagnostic pin: open collector active low or push-pull active high
// assumes the pad resolves the wire from out and the active-low output enable
`timescale 1ns/1ps
module gcs_diag_drive (
  input  wire logic core_clk_i,
  input  wire logic rst_b_i,
  input  wire logic push_pull_i,
  input  wire logic active_i,
  output logic      pin_o,
  output logic      pin_oe_b_o
);

  // open collector pulls low when active and floats otherwise;
  // push-pull always drives and shows the event high
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      pin_o      <= 1'b0;
      pin_oe_b_o <= 1'b1;             // released: nothing driven in reset
    end else if (push_pull_i) begin
      pin_o      <= active_i;
      pin_oe_b_o <= 1'b0;
    end else begin
      pin_o      <= 1'b0;
      pin_oe_b_o <= ~active_i;
    end
  end

endmodule : gcs_diag_drive

// ===== rtl/gcs_regs.sv
// global configuration and status register bank of the stepper controller
// assumes a serial front end on core_clk_i presenting decoded register accesses,
// and driver, motion and analog blocks that consume the steering outputs
//
// Contract
// - bit 12: irq pin push-pull high, else open-collector
// - bit 13: compare pin push-pull high, else open-collector
// - bit 14 picks hysteresis 1/32, else 1/16
// - bit 15 plus high halt pin stops steps
// - bit 16: target position holds direct coil currents
// - direct coil currents scaled by hold setting
// - direct mode disables velocity current regulation
// - bit 17 routes analog test onto index pin
// - writing one clears a status flag
// - status bit 0 set after any reset
// - status bit 1 latches driver shutdown
// - driver error clear needs temperature back OK
// - status bit 2 latches pump undervoltage
// - driver disabled while pump undervoltage persists
// - counter increments per good UART write
// - reads leave counter unchanged
// - counter frozen in SPI operation
// - counter wraps 255 to 0
`timescale 1ns/1ps
module gcs_regs #(
  parameter int RATE_W = 16
) (
  input  wire logic                            core_clk_i,
  input  wire logic                            rst_b_i,
  // register access from the serial front end
  input  wire logic                            reg_wr_i,
  input  wire logic                            reg_rd_i,
  input  wire logic [6:0]                      reg_addr_i,
  input  wire logic [31:0]                     reg_wdata_i,
  output logic      [31:0]                     reg_rdata_o,
  output logic                                 reg_rvalid_o,
  input  wire logic                            uart_mode_i,
  input  wire logic                            uart_write_ok_i,
  // driver health
  input  wire logic                            drv_shutdown_i,
  input  wire logic                            over_temp_i,
  input  wire logic                            pump_undervoltage_flag_i,
  output logic                                 driver_disable_o,
  // diagnostic pins
  input  wire logic                            irq_event_i,
  input  wire logic                            compare_event_i,
  output logic                                 irq_diag_pin_o,
  output logic                                 irq_diag_pin_oe_b_o,
  output logic                                 compare_diag_pin_o,
  output logic                                 compare_diag_pin_oe_b_o,
  // step frequency comparison
  input  wire logic [RATE_W-1:0]               step_rate_i,
  input  wire logic [RATE_W-1:0]               rate_thresh_i,
  output logic                                 rate_above_o,
  // emergency stop
  input  wire logic                            enc_a_halt_input_i,
  output logic                                 halt_steps_o,
  // direct coil current mode
  input  wire logic [31:0]                     target_position_i,
  input  wire logic [gcs_pkg::GCS_SCALE_W-1:0] standstill_current_scale_i,
  output logic                                 direct_mode_o,
  output logic                                 vel_current_reg_en_o,
  output logic signed [gcs_pkg::GCS_COIL_W-1:0] coil_a_current_o,
  output logic signed [gcs_pkg::GCS_COIL_W-1:0] coil_b_current_o,
  // index pin
  input  wire logic                            enc_index_normal_i,
  input  wire logic                            analog_test_i,
  output logic                                 enc_index_out_pin_o,
  output logic                                 analog_test_en_o
);
  import gcs_pkg::*;

  // ****************************************
  // storage
  // ****************************************
  logic [GCS_CONF_W-1:0]   global_configuration;
  logic [GCS_STATUS_W-1:0] global_status_flags;
  logic [GCS_COUNT_W-1:0]  uart_write_counter;
  logic [GCS_STATUS_W-1:0] clr_req;
  logic                    wr_status;
  logic                    halt_level;

  assign wr_status = reg_wr_i && (reg_addr_i == GCS_ADDR_STATUS);

  // write-one-to-clear mask; driver error clear held off while still hot
  always_comb begin
    clr_req = '0;
    if (wr_status) begin
      clr_req = reg_wdata_i[GCS_STATUS_W-1:0];
      if (over_temp_i) begin
        clr_req[GCS_ST_DRV_ERR] = 1'b0;
      end
    end
  end

  // ****************************************
  // configuration register
  // ****************************************
  // all steering bits clear after reset: open collector, wide band, normal run
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      global_configuration <= GCS_CONF_RST;
    end else if (reg_wr_i && (reg_addr_i == GCS_ADDR_CONF)) begin
      global_configuration <= reg_wdata_i[GCS_CONF_W-1:0];
    end
  end

  // ****************************************
  // global status flags
  // ****************************************
  // a hardware set in the cycle of a clear wins, so no event is lost
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      global_status_flags <= GCS_STATUS_RST;
    end else begin
      global_status_flags[GCS_ST_RESET] <= global_status_flags[GCS_ST_RESET]
                                           & ~clr_req[GCS_ST_RESET];
      global_status_flags[GCS_ST_DRV_ERR] <= drv_shutdown_i
                                           | (global_status_flags[GCS_ST_DRV_ERR]
                                              & ~clr_req[GCS_ST_DRV_ERR]);
      global_status_flags[GCS_ST_PUMP_UNDERVOLTAGE_FLAG] <= pump_undervoltage_flag_i
                                           | (global_status_flags[GCS_ST_PUMP_UNDERVOLTAGE_FLAG]
                                              & ~clr_req[GCS_ST_PUMP_UNDERVOLTAGE_FLAG]);
    end
  end

  // driver kept off for as long as the pump is low, independent of the latched flag
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      driver_disable_o <= 1'b1;
    end else begin
      driver_disable_o <= pump_undervoltage_flag_i;
    end
  end

  // ****************************************
  // interface transmission counter
  // ****************************************
  // only good UART writes count; reads never touch it, natural 8-bit wrap
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      uart_write_counter <= GCS_COUNT_RST;
    end else if (uart_write_ok_i && uart_mode_i) begin
      uart_write_counter <= uart_write_counter + 8'h01;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // answer one cycle after the read strobe; unmapped offsets read zero
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        if (reg_addr_i == GCS_ADDR_CONF) begin
          reg_rdata_o <= {14'h0000, global_configuration};
        end else if (reg_addr_i == GCS_ADDR_STATUS) begin
          reg_rdata_o <= {29'h0000_0000, global_status_flags};
        end else if (reg_addr_i == GCS_ADDR_COUNT) begin
          reg_rdata_o <= {24'h00_0000, uart_write_counter};
        end else begin
          reg_rdata_o <= 32'h0000_0000;
        end
      end
    end
  end

  // ****************************************
  // diagnostic pin drivers
  // ****************************************
  gcs_diag_drive u_irq_drive (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .push_pull_i (global_configuration[GCS_BIT_IRQ_PP]),
    .active_i    (irq_event_i),
    .pin_o       (irq_diag_pin_o),
    .pin_oe_b_o  (irq_diag_pin_oe_b_o)
  );

  gcs_diag_drive u_cmp_drive (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .push_pull_i (global_configuration[GCS_BIT_CMP_PP]),
    .active_i    (compare_event_i),
    .pin_o       (compare_diag_pin_o),
    .pin_oe_b_o  (compare_diag_pin_oe_b_o)
  );

  // ****************************************
  // step frequency comparison with hysteresis
  // ****************************************
  logic [2:0]        hys_shift;
  logic [RATE_W-1:0] hys_band;
  logic [RATE_W:0]   upper_lim;
  logic [RATE_W:0]   lower_lim;

  // band is threshold/16 or threshold/32
  always_comb begin
    hys_shift = global_configuration[GCS_BIT_SMALL_HYS] ? GCS_HYS_NARROW : GCS_HYS_WIDE;
    hys_band  = rate_thresh_i >> hys_shift;
    upper_lim = {1'b0, rate_thresh_i} + {1'b0, hys_band};
    lower_lim = {1'b0, rate_thresh_i} - {1'b0, hys_band};
  end

  // switch up above the upper edge, down below the lower one; hold in between
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      rate_above_o <= 1'b0;
    end else if ({1'b0, step_rate_i} > upper_lim) begin
      rate_above_o <= 1'b1;
    end else if ({1'b0, step_rate_i} < lower_lim) begin
      rate_above_o <= 1'b0;
    end
  end

  // ****************************************
  // emergency stop
  // ****************************************
  gcs_pin_sync u_halt_sync (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .pin_i      (enc_a_halt_input_i),
    .level_o    (halt_level)
  );

  // sequencer stops issuing steps and drops to standstill while this is high
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      halt_steps_o <= 1'b0;
    end else begin
      halt_steps_o <= global_configuration[GCS_BIT_STOP_EN] & halt_level;
    end
  end

  // ****************************************
  // direct coil current mode
  // ****************************************
  logic signed [GCS_COIL_W-1:0]    coil_a_raw;
  logic signed [GCS_COIL_W-1:0]    coil_b_raw;
  logic signed [GCS_SCALE_W+1:0]   scale_factor;
  logic signed [GCS_COIL_W+GCS_SCALE_W+1:0] coil_a_prod;
  logic signed [GCS_COIL_W+GCS_SCALE_W+1:0] coil_b_prod;

  // hold setting 0..31 maps to (n+1)/32 of the programmed value
  always_comb begin
    coil_a_raw   = $signed(target_position_i[GCS_COIL_A_LSB +: GCS_COIL_W]);
    coil_b_raw   = $signed(target_position_i[GCS_COIL_B_LSB +: GCS_COIL_W]);
    scale_factor = $signed({2'b00, standstill_current_scale_i}) + 7'sd1;
    coil_a_prod  = (coil_a_raw * scale_factor) >>> GCS_SCALE_SHIFT;
    coil_b_prod  = (coil_b_raw * scale_factor) >>> GCS_SCALE_SHIFT;
  end

  // coil outputs are zero outside direct mode so the driver cannot pick up stale values
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      direct_mode_o        <= 1'b0;
      vel_current_reg_en_o <= 1'b1;
      coil_a_current_o     <= '0;
      coil_b_current_o     <= '0;
    end else begin
      direct_mode_o        <= global_configuration[GCS_BIT_DIRECT];
      vel_current_reg_en_o <= ~global_configuration[GCS_BIT_DIRECT];
      if (global_configuration[GCS_BIT_DIRECT]) begin
        coil_a_current_o <= coil_a_prod[GCS_COIL_W-1:0];
        coil_b_current_o <= coil_b_prod[GCS_COIL_W-1:0];
      end else begin
        coil_a_current_o <= '0;
        coil_b_current_o <= '0;
      end
    end
  end

  // ****************************************
  // index pin and analog test output
  // ****************************************
  // analog path takes over the pin; normal index signal is lost while testing
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      analog_test_en_o    <= 1'b0;
      enc_index_out_pin_o <= 1'b0;
    end else begin
      analog_test_en_o    <= global_configuration[GCS_BIT_TEST];
      enc_index_out_pin_o <= global_configuration[GCS_BIT_TEST] ? analog_test_i
                                                                 : enc_index_normal_i;
    end
  end

endmodule : gcs_regs

// ===== dv/gcs_regs_assertions.sv
// checker for the global configuration and status register bank
// assumes it is bound to gcs_regs and sees only that module's ports
`timescale 1ns/1ps
module gcs_regs_chk
  import gcs_pkg::*;
#(
  parameter int RATE_W = 16
) (
  input wire logic              core_clk_i,
  input wire logic              rst_b_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [6:0]        reg_addr_i,
  input wire logic [31:0]       reg_wdata_i,
  input wire logic [31:0]       reg_rdata_o,
  input wire logic              reg_rvalid_o,
  input wire logic              uart_mode_i,
  input wire logic              uart_write_ok_i,
  input wire logic              pump_undervoltage_flag_i,
  input wire logic              driver_disable_o,
  input wire logic              irq_event_i,
  input wire logic              compare_event_i,
  input wire logic              irq_diag_pin_o,
  input wire logic              irq_diag_pin_oe_b_o,
  input wire logic              compare_diag_pin_o,
  input wire logic              compare_diag_pin_oe_b_o,
  input wire logic [RATE_W-1:0] step_rate_i,
  input wire logic [RATE_W-1:0] rate_thresh_i,
  input wire logic              rate_above_o,
  input wire logic              enc_a_halt_input_i,
  input wire logic              halt_steps_o,
  input wire logic              direct_mode_o,
  input wire logic              vel_current_reg_en_o
);
  // ****************************************
  // shadow state rebuilt from the bus
  // ****************************************
  logic [17:0] conf;
  logic [7:0]  cnt;

  // configuration copy; the bank itself is not visible from here
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) conf <= '0;
    else if (reg_wr_i && reg_addr_i == GCS_ADDR_CONF) conf <= reg_wdata_i[17:0];
  end

  // expected write count, wraps by itself at eight bits
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) cnt <= '0;
    else if (uart_write_ok_i && uart_mode_i) cnt <= cnt + 8'h01;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_rv; reg_rd_i |=> reg_rvalid_o ##1 (reg_rvalid_o == $past(reg_rd_i)); endproperty
  a_rv: assert property (p_rv) else $error("read answer not a single pulse");
  property p_irq; $past(rst_b_i) && $past(conf[12]) |-> !irq_diag_pin_oe_b_o && irq_diag_pin_o == $past(irq_event_i); endproperty
  a_irq: assert property (p_irq) else $error("irq pin not push-pull active high");
  property p_cmp; $past(rst_b_i) && !$past(conf[13]) |-> compare_diag_pin_oe_b_o == !$past(compare_event_i) && !compare_diag_pin_o; endproperty
  a_cmp: assert property (p_cmp) else $error("compare pin not open collector");
  property p_hys; {1'b0, step_rate_i} > {1'b0, rate_thresh_i} + (rate_thresh_i >> (conf[14] ? 5 : 4)) |=> rate_above_o; endproperty
  a_hys: assert property (p_hys) else $error("rate above band not flagged");
  property p_halt; (conf[15] && enc_a_halt_input_i) [*8] |-> halt_steps_o; endproperty
  a_halt: assert property (p_halt) else $error("halt pin ignored");
  property p_dir; $past(rst_b_i) |-> direct_mode_o == $past(conf[16]) && vel_current_reg_en_o == !direct_mode_o; endproperty
  a_dir: assert property (p_dir) else $error("direct mode steering wrong");
  property p_cnt; reg_rd_i && reg_addr_i == GCS_ADDR_COUNT |=> reg_rdata_o == {24'h0000_00, $past(cnt)}; endproperty
  a_cnt: assert property (p_cnt) else $error("write counter value wrong");
  property p_drv; $past(rst_b_i) |-> driver_disable_o == $past(pump_undervoltage_flag_i); endproperty
  a_drv: assert property (p_drv) else $error("driver not held off on undervoltage");
endmodule : gcs_regs_chk

bind gcs_regs gcs_regs_chk #(.RATE_W(RATE_W)) u_chk (.core_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
  .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .uart_mode_i, .uart_write_ok_i, .pump_undervoltage_flag_i,
  .driver_disable_o, .irq_event_i, .compare_event_i, .irq_diag_pin_o, .irq_diag_pin_oe_b_o, .compare_diag_pin_o,
  .compare_diag_pin_oe_b_o, .step_rate_i, .rate_thresh_i, .rate_above_o, .enc_a_halt_input_i, .halt_steps_o,
  .direct_mode_o, .vel_current_reg_en_o);

// ===== dv/gcs_host_model.sv
// host model: issues decoded register accesses as the serial front end would
// assumes the bank's clock; requests launch 1 ns after a rising edge
`timescale 1ns/1ps
module gcs_host_model (
  input  wire logic        core_clk_i,
  input  wire logic [31:0] reg_rdata_i,
  input  wire logic        reg_rvalid_i,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic [6:0]       reg_addr_o,
  output logic [31:0]      reg_wdata_o,
  output logic             uart_mode_o,
  output logic             uart_write_ok_o
);
  // idle bus at time zero, spi operation
  initial begin
    {reg_wr_o, reg_rd_o, uart_mode_o, uart_write_ok_o} = 4'h0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 32'h0000_0000;
  end

  // pick spi or uart; every write is flagged good, the bank must ignore it over spi
  task automatic mode(input logic m);
    @(posedge core_clk_i);
    #1;
    uart_mode_o = m;
  endtask : mode

  // one write; released bus shows inverted garbage, not the last value
  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    #1;
    {reg_wr_o, reg_addr_o, reg_wdata_o, uart_write_ok_o} = {1'b1, a, v, 1'b1};
    @(posedge core_clk_i);
    #1;
    {reg_wr_o, reg_addr_o, reg_wdata_o, uart_write_ok_o} = {1'b0, ~a, ~v, 1'b0};
  endtask : wr

  // one read; a missing answer comes back unknown so it never matches
  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    #1;
    {reg_rd_o, reg_addr_o} = {1'b1, a};
    @(posedge core_clk_i);
    #1;
    {reg_rd_o, reg_addr_o} = {1'b0, ~a};
    v = reg_rvalid_i ? reg_rdata_i : 32'hxxxx_xxxx;
  endtask : rd
endmodule : gcs_host_model

// ===== dv/test_global_config_status_regs.sv
// self-checking bench for the global configuration and status register bank
// assumes the package, the bank, its checker bind and the host model are compiled first
`timescale 1ns/1ps
module test_global_config_status_regs;
  import gcs_pkg::*;
  logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, reg_rvalid_o, uart_mode_i, uart_write_ok_i, rate_above_o;
  logic drv_shutdown_i, over_temp_i, pump_undervoltage_flag_i, driver_disable_o, halt_steps_o;
  logic irq_event_i, compare_event_i, irq_diag_pin_o, irq_diag_pin_oe_b_o, enc_a_halt_input_i;
  logic compare_diag_pin_o, compare_diag_pin_oe_b_o, direct_mode_o, vel_current_reg_en_o;
  logic enc_index_normal_i, analog_test_i, enc_index_out_pin_o, analog_test_en_o;
  logic        [6:0]  reg_addr_i;
  logic        [31:0] reg_wdata_i, reg_rdata_o, target_position_i;
  logic        [15:0] step_rate_i, rate_thresh_i;
  logic        [4:0]  standstill_current_scale_i;
  logic signed [8:0]  coil_a_current_o, coil_b_current_o;
  int                 n_errors, comparisons;

  gcs_regs #(.RATE_W(16)) dut (.core_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .uart_mode_i, .uart_write_ok_i, .drv_shutdown_i, .over_temp_i, .pump_undervoltage_flag_i,
    .driver_disable_o, .irq_event_i, .compare_event_i, .irq_diag_pin_o, .irq_diag_pin_oe_b_o, .compare_diag_pin_o,
    .compare_diag_pin_oe_b_o, .step_rate_i, .rate_thresh_i, .rate_above_o, .enc_a_halt_input_i, .halt_steps_o,
    .target_position_i, .standstill_current_scale_i, .direct_mode_o, .vel_current_reg_en_o, .coil_a_current_o,
    .coil_b_current_o, .enc_index_normal_i, .analog_test_i, .enc_index_out_pin_o, .analog_test_en_o);
  gcs_host_model host (.core_clk_i, .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o), .reg_wr_o(reg_wr_i),
    .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i), .uart_mode_o(uart_mode_i),
    .uart_write_ok_o(uart_write_ok_i));

  // ****************************************
  // clock, checks and closing
  // ****************************************
  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic rchk(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    chk(v, exp);
  endtask : rchk

  // land just after an edge so every registered output has settled
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask : wait_n

  task automatic conf(input logic [31:0] v);
    host.wr(GCS_ADDR_CONF, v);
    wait_n(2);
  endtask : conf

  task automatic end_of_test;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  // a hang counts as a mismatch; the run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge core_clk_i);
    n_errors++;
    end_of_test();
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {drv_shutdown_i, over_temp_i, pump_undervoltage_flag_i, irq_event_i, compare_event_i} = 5'h00;
    {enc_a_halt_input_i, enc_index_normal_i, analog_test_i, rst_b_i} = 4'h0;
    {step_rate_i, rate_thresh_i, target_position_i, standstill_current_scale_i} = '0;
    wait_n(4);
    chk({driver_disable_o, vel_current_reg_en_o}, 32'h0000_0003);
    rst_b_i = 1'b1;
    rchk(GCS_ADDR_CONF, 32'h0000_0000);
    rchk(GCS_ADDR_STATUS, 32'h0000_0001);
    rchk(7'h7F, 32'h0000_0000);
    host.wr(GCS_ADDR_STATUS, 32'h0000_0000);
    rchk(GCS_ADDR_STATUS, 32'h0000_0001);
    host.wr(GCS_ADDR_STATUS, 32'h0000_0001);
    rchk(GCS_ADDR_STATUS, 32'h0000_0000);
    conf(32'h0003_F000);
    rchk(GCS_ADDR_CONF, 32'h0003_F000);
    // driver error stays until the temperature is back below its limit
    {over_temp_i, drv_shutdown_i} = 2'b11;
    wait_n(1);
    drv_shutdown_i = 1'b0;
    host.wr(GCS_ADDR_STATUS, 32'h0000_0002);
    rchk(GCS_ADDR_STATUS, 32'h0000_0002);
    over_temp_i = 1'b0;
    host.wr(GCS_ADDR_STATUS, 32'h0000_0002);
    rchk(GCS_ADDR_STATUS, 32'h0000_0000);
    pump_undervoltage_flag_i = 1'b1;
    wait_n(3);
    chk(driver_disable_o, 32'h0000_0001);
    pump_undervoltage_flag_i = 1'b0;
    wait_n(3);
    rchk(GCS_ADDR_STATUS, 32'h0000_0004);
    host.wr(GCS_ADDR_STATUS, 32'h0000_0004);
    rchk(GCS_ADDR_STATUS, 32'h0000_0000);
    // both diagnostic pins in every drive style with the event idle and active
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 2; e++) begin
        conf(32'(m << 12));
        {irq_event_i, compare_event_i} = {e[0], e[0]};
        wait_n(2);
        chk({irq_diag_pin_oe_b_o, irq_diag_pin_o}, m[0] ? {1'b0, e[0]} : {!e[0], 1'b0});
        chk({compare_diag_pin_oe_b_o, compare_diag_pin_o}, m[1] ? {1'b0, e[0]} : {!e[0], 1'b0});
      end
    end
    // threshold 256: wide band 240..272, narrow band 248..264
    rate_thresh_i = 16'h0100;
    step_rate_i = 16'h010E;
    conf(32'h0000_0000);
    chk(rate_above_o, 32'h0000_0000);
    conf(32'h0000_4000);
    chk(rate_above_o, 32'h0000_0001);
    conf(32'h0000_0000);
    step_rate_i = 16'h00F6;
    wait_n(2);
    chk(rate_above_o, 32'h0000_0001);
    conf(32'h0000_4000);
    chk(rate_above_o, 32'h0000_0000);
    conf(32'h0000_8000);
    enc_a_halt_input_i = 1'b1;
    wait_n(8);
    chk(halt_steps_o, 32'h0000_0001);
    conf(32'h0000_0000);
    chk(halt_steps_o, 32'h0000_0000);
    enc_a_halt_input_i = 1'b0;
    // coil A 255 and coil B -16, at full and about half hold current
    {target_position_i, standstill_current_scale_i} = {32'h01F0_00FF, 5'h1F};
    wait_n(2);
    chk({direct_mode_o, vel_current_reg_en_o, coil_b_current_o, coil_a_current_o}, 32'h0004_0000);
    conf(32'h0001_0000);
    chk({direct_mode_o, vel_current_reg_en_o, coil_b_current_o, coil_a_current_o}, 32'h000B_E0FF);
    standstill_current_scale_i = 5'h0F;
    wait_n(2);
    chk({coil_b_current_o, coil_a_current_o}, 32'h0003_F07F);
    {analog_test_i, enc_index_normal_i} = 2'b10;
    conf(32'h0002_0000);
    chk({analog_test_en_o, enc_index_out_pin_o}, 32'h0000_0003);
    {analog_test_i, enc_index_normal_i} = 2'b01;
    conf(32'h0000_0000);
    chk({analog_test_en_o, enc_index_out_pin_o}, 32'h0000_0001);
    // counter: frozen over spi, read-only, then 256 uart writes wrap it
    host.wr(GCS_ADDR_COUNT, 32'h0000_00FF);
    rchk(GCS_ADDR_COUNT, 32'h0000_0000);
    host.mode(1'b1);
    for (int i = 0; i < 3; i++) host.wr(GCS_ADDR_STATUS, 32'h0000_0000);
    rchk(GCS_ADDR_COUNT, 32'h0000_0003);
    rchk(GCS_ADDR_COUNT, 32'h0000_0003);
    for (int i = 0; i < 252; i++) host.wr(GCS_ADDR_STATUS, 32'h0000_0000);
    rchk(GCS_ADDR_COUNT, 32'h0000_00FF);
    host.wr(GCS_ADDR_STATUS, 32'h0000_0000);
    rchk(GCS_ADDR_COUNT, 32'h0000_0000);
    conf(32'h0003_F000);
    rst_b_i = 1'b0;
    wait_n(4);
    rst_b_i = 1'b1;
    rchk(GCS_ADDR_STATUS, 32'h0000_0001);
    rchk(GCS_ADDR_CONF, 32'h0000_0000);
    end_of_test();
  end
endmodule : test_global_config_status_regs
